// >>> tb_top.sv
// Purpose: Self-checking bench for the wake enable and SMI status register bank
// Assumes: Register port answers a read in the cycle after the strobe
// Notes: Random stimulus from a fixed xorshift seed, corner cases mixed in
`timescale 1ns/100ps
module tb_top;
  import wsr_pkg::*;
  logic clk = 0, rst = 1, standby_por = 1, wr = 0, rd = 0, irq, wake_event_out_n;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, wake_pins = 8'h00;
  logic printer_acknowledge_in_n = 1, serial_two_irq = 0, serial_one_irq = 0;
  logic floppy_irq = 0, midi_irq = 0;
  int mismatches = 0, checks_done = 0, cycles = 0;
  logic [31:0] seed = 32'hed7eee69;
  wsr_byte_t d, e, p;
  always #5 clk = ~clk;
  wsr_top u_wsr_top (.clk(clk), .rst(rst), .standby_por(standby_por), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wake_pins(wake_pins),
    .printer_acknowledge_in_n(printer_acknowledge_in_n), .serial_two_irq(serial_two_irq),
    .serial_one_irq(serial_one_irq), .floppy_irq(floppy_irq), .midi_irq(midi_irq),
    .wake_event_out_n(wake_event_out_n), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected SMI byte from peripheral levels; bits 7:6 and 0 stay zero
  function automatic wsr_byte_t smi_exp(input logic act, input logic ack, input logic [3:0] s);
    return {2'b00, s, act ? ack : 1'b1, 1'b0};
  endfunction
  task automatic complete_run();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    rreg(a, d);
    chk(d, exp);
  endtask
  task automatic settle();
    repeat (10) @(posedge clk);
  endtask
  // Hang guard: generous for the short directed sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles > 8000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    standby_por <= 0;
    rchk(8'h0e, 8'h00);
    rchk(8'h10, 8'h02);
    rchk(8'h0f, 8'h00);
    wreg(8'h0f, 8'hff);
    rchk(8'h0f, 8'h00);
    wreg(8'h10, 8'hff);
    rchk(8'h10, 8'h02);
    // Wake gating, with an all-disabled corner first
    wreg(8'h23, 8'h01);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      e = (i == 0) ? 8'h00 : seed[7:0];
      p = (i == 0) ? 8'hff : seed[15:8];
      wreg(8'h0e, e);
      rchk(8'h0e, e);
      wake_pins <= p;
      settle();
      chk(wake_event_out_n, ~|(e & p));
      rchk(8'h22, p);
      wake_pins <= 8'h00;
      settle();
      wreg(8'h22, 8'hff);
    end
    // Global enable off hides every source
    wreg(8'h0e, 8'hff);
    wreg(8'h23, 8'h00);
    wake_pins <= 8'hff;
    settle();
    chk(wake_event_out_n, 1'b1);
    wake_pins <= 8'h00;
    // SMI sources, parallel bit idle then tracking the ack pin
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      {midi_irq, floppy_irq, serial_one_irq, serial_two_irq} <= seed[3:0];
      printer_acknowledge_in_n <= seed[4];
      if (i == 4)
        wreg(8'h23, 8'h02);
      settle();
      wreg(8'h10, 8'h00);
      rchk(8'h10, smi_exp(i >= 4, seed[4], seed[3:0]));
    end
    {midi_irq, floppy_irq, serial_one_irq, serial_two_irq} <= 4'h0;
    settle();
    // Interrupt: masked, then unmasked, then cleared by writing one
    wreg(8'h21, 8'h00);
    wreg(8'h20, 8'hff);
    midi_irq <= 1;
    settle();
    chk(irq, 1'b0);
    rreg(8'h20, d);
    chk(d[5], 1'b1);
    wreg(8'h21, 8'hff);
    settle();
    chk(irq, 1'b1);
    wreg(8'h20, 8'h20);
    settle();
    chk(irq, 1'b0);
    midi_irq <= 0;
    // Main reset keeps the enables, standby reset clears them
    wreg(8'h0e, 8'ha5);
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rchk(8'h0e, 8'ha5);
    settle();
    rchk(8'h10, 8'h02);
    @(posedge clk);
    rst <= 1;
    standby_por <= 1;
    repeat (5) @(posedge clk);
    rst <= 0;
    standby_por <= 0;
    rchk(8'h0e, 8'h00);
    complete_run();
  end
endmodule

// >>> wsr_defs.svh
// Purpose: Offsets, field positions and reset values for the wake/SMI register bank
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Register bank keeps wake enables across main resets
// Function
// - Eight-bit wake enable at 0x0e, bit per pin
// - Enable, status and global enable drive wake low
// - Disabled source still recorded, no wake output
// - Enables cleared only by standby power reset
// - Offset 0x0f reads zero, read only
// - SMI status at 0x10 mirrors peripheral interrupts
// - SMI bits ignore writes, clear at source
// - Parallel bit one until port activated, then ack
// - SMI status defaults 0x02 on every reset
`ifndef WSR_DEFS_SVH
`define WSR_DEFS_SVH
`define WSR_OFF_WAKE_EN 8'h0e
`define WSR_OFF_RSVD 8'h0f
`define WSR_OFF_SMI_STS 8'h10
`define WSR_OFF_IRQ_STS 8'h20
`define WSR_OFF_IRQ_MASK 8'h21
`define WSR_OFF_WAKE_STS 8'h22
`define WSR_OFF_CTRL 8'h23
`define WSR_WAKE_EN_RST 8'h00
`define WSR_SMI_RST 8'h02
`define WSR_BIT_PAR 1
`define WSR_BIT_SER2 2
`define WSR_BIT_SER1 3
`define WSR_BIT_FLOPPY 4
`define WSR_BIT_MIDI 5
`define WSR_CTRL_GLOBAL 0
`define WSR_CTRL_PAR_ACT 1
`endif

// >>> wsr_pkg.sv
// Purpose: Types for the wake/SMI register bank
// Assumes: Nothing beyond the defs header
// Notes: Types only
package wsr_pkg;
  typedef logic [7:0] wsr_byte_t;
endpackage

// >>> wsr_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a bus of pins
// Assumes: Inputs asynchronous to clk
// Notes: Output changes once stages two and three agree
`timescale 1ns/100ps
module wsr_sync
  import wsr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  // Stage one feeds only stage two to keep metastability contained
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // Accept a new level only when two stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flt
      always_ff @(posedge clk) begin
        if (rst) begin
          dout[i] <= INIT[i];
        end else if (s2[i] == s3[i]) begin
          dout[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule

// >>> wsr_top.sv
// Purpose: Wake-enable and SMI status register bank with interrupt status
// Assumes: Plain register port, read data one cycle after read strobe
// Notes: rst is main-power reset; standby_por separate active-high standby reset
//
// The implementer's own choice: the strobed register port.
`include "wsr_defs.svh"
`timescale 1ns/100ps
module wsr_top
  import wsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic standby_por,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] wake_pins,
  input wire logic printer_acknowledge_in_n,
  input wire logic serial_two_irq,
  input wire logic serial_one_irq,
  input wire logic floppy_irq,
  input wire logic midi_irq,
  output logic wake_event_out_n,
  output logic irq
);
  wsr_byte_t wake_source_enable_five;
  wsr_byte_t wake_status;
  wsr_byte_t smi_source_status_one;
  wsr_byte_t irq_status;
  wsr_byte_t irq_mask;
  logic global_wake_event_enable;
  logic par_active;
  logic [7:0] pins_s;
  logic [4:0] per_s;
  logic [4:0] per_prev;
  wsr_byte_t next_smi;
  logic [7:0] next_rdata;

  wsr_sync #(.WIDTH(8), .INIT(8'h00)) u_pin_sync (
    .clk(clk),
    .rst(rst),
    .din(wake_pins),
    .dout(pins_s)
  );
  wsr_sync #(.WIDTH(5), .INIT(5'h01)) u_per_sync (
    .clk(clk),
    .rst(rst),
    .din({midi_irq, floppy_irq, serial_one_irq, serial_two_irq, printer_acknowledge_in_n}),
    .dout(per_s)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Wake enables reset only by standby power, main resets leave them
  always_ff @(posedge clk) begin
    if (standby_por) begin
      wake_source_enable_five <= `WSR_WAKE_EN_RST;
    end else if (wr && hit(addr, `WSR_OFF_WAKE_EN)) begin
      wake_source_enable_five <= wdata;
    end
  end

  // Global enable bit also survives main reset alongside the enables
  always_ff @(posedge clk) begin
    if (standby_por) begin
      global_wake_event_enable <= 1'b0;
    end else if (wr && hit(addr, `WSR_OFF_CTRL)) begin
      global_wake_event_enable <= wdata[`WSR_CTRL_GLOBAL];
    end
  end

  // Port activate follows main resets so the parallel bit returns to one
  always_ff @(posedge clk) begin
    if (rst || standby_por) begin
      par_active <= 1'b0;
    end else if (wr && hit(addr, `WSR_OFF_CTRL)) begin
      par_active <= wdata[`WSR_CTRL_PAR_ACT];
    end
  end

  // Wake status latches high pin levels regardless of enables; write one clears
  always_ff @(posedge clk) begin
    if (rst || standby_por) begin
      wake_status <= 8'h00;
    end else begin
      wake_status <= pins_s | (wake_status & ~((wr && hit(addr, `WSR_OFF_WAKE_STS)) ? wdata : 8'h00));
    end
  end

  // SMI status mirrors sources; software writes have no effect
  always_comb begin
    next_smi = 8'h00;
    next_smi[`WSR_BIT_PAR] = par_active ? per_s[0] : 1'b1;
    next_smi[`WSR_BIT_SER2] = per_s[1];
    next_smi[`WSR_BIT_SER1] = per_s[2];
    next_smi[`WSR_BIT_FLOPPY] = per_s[3];
    next_smi[`WSR_BIT_MIDI] = per_s[4];
  end

  always_ff @(posedge clk) begin
    if (rst || standby_por) begin
      smi_source_status_one <= `WSR_SMI_RST;
    end else begin
      smi_source_status_one <= next_smi;
    end
  end

  // Interrupt events: rising SMI sources; set wins over a write-one clear
  always_ff @(posedge clk) begin
    if (rst || standby_por) begin
      per_prev <= 5'h00;
      irq_status <= 8'h00;
    end else begin
      per_prev <= next_smi[5:1];
      irq_status <= {2'b00, next_smi[5:1] & ~per_prev, 1'b0}
        | (irq_status & ~((wr && hit(addr, `WSR_OFF_IRQ_STS)) ? wdata : 8'h00));
    end
  end

  always_ff @(posedge clk) begin
    if (rst || standby_por) begin
      irq_mask <= 8'h00;
    end else if (wr && hit(addr, `WSR_OFF_IRQ_MASK)) begin
      irq_mask <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || standby_por) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  wsr_wake_gate u_gate (
    .clk(clk),
    .rst(rst),
    .wake_status(wake_status),
    .wake_enable(wake_source_enable_five),
    .global_wake_event_enable(global_wake_event_enable),
    .wake_event_out_n(wake_event_out_n)
  );

  // Read mux; unmapped and reserved offsets answer zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      `WSR_OFF_WAKE_EN: next_rdata = wake_source_enable_five;
      `WSR_OFF_RSVD: next_rdata = 8'h00;
      `WSR_OFF_SMI_STS: next_rdata = smi_source_status_one;
      `WSR_OFF_IRQ_STS: next_rdata = irq_status;
      `WSR_OFF_IRQ_MASK: next_rdata = irq_mask;
      `WSR_OFF_WAKE_STS: next_rdata = wake_status;
      `WSR_OFF_CTRL: next_rdata = {6'h00, par_active, global_wake_event_enable};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  chk_enable_keeps: assert property (@(posedge clk) disable iff (standby_por)
    rst |=> $stable(wake_source_enable_five)) else $error("wake enable lost on reset");
  chk_standby_clears: assert property (@(posedge clk)
    standby_por |=> wake_source_enable_five == 8'h00) else $error("standby clear failed");
  chk_wake_asserts: assert property (@(posedge clk) disable iff (rst || standby_por)
    (global_wake_event_enable && |(wake_status & wake_source_enable_five)) |=> !wake_event_out_n)
    else $error("wake not asserted");
  chk_wake_masked: assert property (@(posedge clk) disable iff (rst || standby_por)
    !(|(wake_status & wake_source_enable_five)) |=> wake_event_out_n)
    else $error("wake asserted while disabled");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
    rd && addr == `WSR_OFF_RSVD |=> rdata == 8'h00) else $error("reserved read nonzero");
  chk_smi_upper_zero: assert property (@(posedge clk) disable iff (rst || standby_por)
    smi_source_status_one[7:6] == 2'b00 && !smi_source_status_one[0])
    else $error("smi reserved bits set");
  chk_par_default: assert property (@(posedge clk) disable iff (rst || standby_por)
    !par_active |=> smi_source_status_one[`WSR_BIT_PAR]) else $error("parallel bit not one");
  chk_smi_reset: assert property (@(posedge clk)
    rst |=> smi_source_status_one == 8'h02) else $error("smi reset value wrong");
  chk_smi_read: assert property (@(posedge clk) disable iff (rst || standby_por)
    rd && addr == `WSR_OFF_SMI_STS |=> rdata == $past(smi_source_status_one))
    else $error("smi read mismatch");
  chk_smi_nowrite: assert property (@(posedge clk) disable iff (rst || standby_por)
    wr && addr == `WSR_OFF_SMI_STS |=> smi_source_status_one == $past(next_smi))
    else $error("smi changed by write");
  cov_wake: cover property (@(posedge clk) !wake_event_out_n);
  cov_irq: cover property (@(posedge clk) irq);
  cov_par_track: cover property (@(posedge clk) par_active && !smi_source_status_one[1]);

  // Main reset must leave the enables standing; standby power is the only way back to zero
  cov_enable_survives: cover property (@(posedge clk)
    rst ##1 (!rst && wake_source_enable_five != 8'h00));
  cov_wake_clear: cover property (@(posedge clk) wr && addr == `WSR_OFF_WAKE_STS);

  // Interrupt output is a registered view of unmasked status, one cycle behind
  chk_irq_raises: assert property (@(posedge clk) disable iff (rst || standby_por)
    |(irq_status & irq_mask) |=> irq) else $error("irq not raised");
  chk_irq_quiet: assert property (@(posedge clk) disable iff (rst || standby_por)
    !(|(irq_status & irq_mask)) |=> !irq) else $error("irq raised while masked");
  chk_irq_reset: assert property (@(posedge clk)
    rst |=> !irq && irq_status == 8'h00) else $error("irq state survived reset");

  // Read data must idle at zero so a stale byte is never mistaken for an answer
  chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 8'h00) else $error("read data not idle");
  chk_ctrl_read: assert property (@(posedge clk) disable iff (rst || standby_por)
    rd && addr == `WSR_OFF_CTRL |=> rdata == {6'h00, $past(par_active),
    $past(global_wake_event_enable)}) else $error("control read mismatch");

  // Writes land on the very next edge; there is no posted-write queue
  chk_enable_write: assert property (@(posedge clk) disable iff (standby_por)
    wr && addr == `WSR_OFF_WAKE_EN |=> wake_source_enable_five == $past(wdata))
    else $error("wake enable write lost");
  chk_mask_write: assert property (@(posedge clk) disable iff (rst || standby_por)
    wr && addr == `WSR_OFF_IRQ_MASK |=> irq_mask == $past(wdata))
    else $error("mask write lost");

  // Control bits: global enable lives in the standby domain, activate in the main one
  chk_global_standby: assert property (@(posedge clk)
    standby_por |=> !global_wake_event_enable) else $error("global enable kept");
  chk_global_keep: assert property (@(posedge clk) disable iff (standby_por)
    rst && !wr |=> $stable(global_wake_event_enable)) else $error("global enable lost");
  chk_par_reset: assert property (@(posedge clk)
    rst |=> !par_active) else $error("port activate kept over reset");
  chk_ctrl_standby_par: assert property (@(posedge clk)
    standby_por |=> !par_active) else $error("activate kept over standby");
  chk_wake_idle: assert property (@(posedge clk)
    rst |=> wake_event_out_n) else $error("wake out low after reset");

  // Wake status records every high pin whatever the enables say
  chk_wake_records: assert property (@(posedge clk) disable iff (rst || standby_por)
    1'b1 |=> (wake_status & $past(pins_s)) == $past(pins_s))
    else $error("wake event not recorded");
  chk_wake_sticky: assert property (@(posedge clk) disable iff (rst || standby_por)
    !(wr && addr == `WSR_OFF_WAKE_STS) |=>
    (wake_status & $past(wake_status)) == $past(wake_status))
    else $error("wake status dropped without a write");
  chk_irq_sticky: assert property (@(posedge clk) disable iff (rst || standby_por)
    !(wr && addr == `WSR_OFF_IRQ_STS) |=>
    (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("irq status dropped without a write");

  // One checker per serial, floppy and MIDI SMI bit (2 to 5); each is only ever a delayed pin level
  genvar b;
  generate
    for (b = 2; b < 6; b++) begin : g_smi_chk
      chk_smi_follows: assert property (@(posedge clk) disable iff (rst || standby_por)
        1'b1 |=> smi_source_status_one[b] == $past(per_s[b-1]))
        else $error("smi bit does not follow its source");
    end
  endgenerate

  // A rising source must always leave its interrupt status bit set
  genvar k;
  generate
    for (k = 1; k < 6; k++) begin : g_irq_chk
      chk_irq_edge_sets: assert property (@(posedge clk) disable iff (rst || standby_por)
        next_smi[k] && !per_prev[k-1] |=> irq_status[k])
        else $error("rising source missed");
    end
  endgenerate

  // The status byte never accepts data from software
  chk_smi_upper_stays: assert property (@(posedge clk) disable iff (rst || standby_por)
    wr && addr == `WSR_OFF_SMI_STS |=> smi_source_status_one[7:6] == 2'b00)
    else $error("smi upper bits took a write");
  chk_par_active_one: assert property (@(posedge clk) disable iff (rst || standby_por)
    par_active |=> smi_source_status_one[`WSR_BIT_PAR] == $past(per_s[0]))
    else $error("parallel bit not tracking ack");

  // Wake status clear: a written one drops the bit unless the pin is still high
  chk_wake_clear: assert property (@(posedge clk) disable iff (rst || standby_por)
    wr && addr == `WSR_OFF_WAKE_STS |=>
    wake_status == ($past(pins_s) | ($past(wake_status) & ~$past(wdata))))
    else $error("wake status clear wrong");
  chk_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    rd && addr > `WSR_OFF_CTRL |=> rdata == 8'h00) else $error("unmapped read nonzero");

  // Standby power also clears the main-domain state, all but rdata, the wake output and both synchronisers, which follow rst only
  chk_standby_smi: assert property (@(posedge clk)
    standby_por |=> smi_source_status_one == `WSR_SMI_RST) else $error("smi not reset");
  chk_standby_mask: assert property (@(posedge clk)
    standby_por |=> irq_mask == 8'h00 && wake_status == 8'h00)
    else $error("standby left status or mask");
  chk_rdata_reset: assert property (@(posedge clk)
    rst |=> rdata == 8'h00) else $error("read data survived reset");
  chk_wake_sts_reset: assert property (@(posedge clk)
    rst |=> wake_status == 8'h00) else $error("wake status survived reset");
endmodule

// >>> wsr_wake_gate.sv
// Purpose: Gates enabled wake sources onto one active-low wake output
// Assumes: Status and enables on clk
// Notes: Registered output
`timescale 1ns/100ps
module wsr_wake_gate
  import wsr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wake_status,
  input wire logic [7:0] wake_enable,
  input wire logic global_wake_event_enable,
  output logic wake_event_out_n
);
  // Disabled sources are masked here only; their status stays recorded
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_event_out_n <= 1'b1;
    end else begin
      wake_event_out_n <= ~(global_wake_event_enable && |(wake_status & wake_enable));
    end
  end
endmodule
